// ---- supervisor_pkg.sv ----
package supervisor_pkg;
   // APB register byte addresses
   localparam logic [7:0] ADDR_RETRY = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MOTOR2_BASE = 8'h10;
   localparam int MOTOR2_WORDS = 10;
   // Field positions in the control register
   localparam int CTRL_FAN_MODE = 0;
   localparam int CTRL_FAN_FAULT = 1;
   localparam int CTRL_IN5_LSB = 8;
   localparam int CTRL_DO_LSB = 16;
   localparam int CTRL_RO_LSB = 24;
   // Ranges, defaults and codes
   localparam logic [3:0] RETRY_MAX = 4'hA;
   localparam logic [3:0] RETRY_RESET = 4'h0;
   localparam logic [9:0] DELAY_MAX = 10'h258;
   localparam logic [9:0] DELAY_RESET = 10'h00A;
   localparam logic [4:0] SEL_MOTOR2 = 5'h0C;
   localparam logic [4:0] OUT_FAULT = 5'h11;
   localparam logic [4:0] OUT_FAN_ALARM = 5'h12;
   localparam logic [4:0] OUT_SEL_MAX = 5'h12;
   localparam logic [4:0] IN5_RESET = 5'h07;
   localparam logic [4:0] DO_RESET = 5'h0C;
   localparam logic [4:0] RO_RESET = 5'h11;
   // Time base: 0.1 s ticks from the 25 MHz clock
   localparam int CLK_HZ = 25000000;
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int QUIET_S = 30;
   localparam int QUIET_TICKS = QUIET_S * 1000 / TICK_MS;
   typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_LOCK} restart_state_t;
endpackage : supervisor_pkg

// ---- supervisor_if.sv ----
`timescale 1ns/1ps
// Slow tick and fan fault signals shared by the sub-blocks
interface supervisor_if;
   logic tick;
   logic fan_fault;
   logic fan_on;
   modport src (output tick);
   modport sink (input tick);
   modport fan (input tick, output fan_on, output fan_fault);
   modport top (input tick, input fan_on, input fan_fault);
endinterface : supervisor_if

// ---- tick_divider.sv ----
`timescale 1ns/1ps
module tick_divider
   import supervisor_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   supervisor_if.src bus
);
   logic [23:0] cnt_q;
   // One-cycle enable every tick period
   always_ff @(posedge clk) begin
      if (srst || cnt_q == 24'(TICK_LEN - 1)) begin
         cnt_q <= 24'h000000;
      end else begin
         cnt_q <= cnt_q + 24'h000001;
      end
   end
   assign bus.tick = (cnt_q == 24'(TICK_LEN - 1)) && !srst;
endmodule : tick_divider

// ---- fan_control.sv ----
`timescale 1ns/1ps
module fan_control
   import supervisor_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic fan_mode,
   input wire logic run_cmd,
   input wire logic output_active,
   input wire logic heatsink_hot,
   input wire logic undervoltage,
   input wire logic fan_fail,
   supervisor_if.fan bus
);
   logic fan_q;
   // Fan demand per control mode; heat overrides the run command
   always_ff @(posedge clk) begin
      if (srst) begin
         fan_q <= 1'b0;
      end else if (!fan_mode) begin
         fan_q <= !undervoltage; // see [R14]
      end else begin
         fan_q <= run_cmd || output_active || heatsink_hot; // see [R15] see [R16]
      end
   end
   assign bus.fan_on = fan_q;
   assign bus.fan_fault = fan_fail;
endmodule : fan_control

// ---- trip_restart_fan_supervisor.sv ----
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Function
// [R1] Retry count setting 0 to 10, default 0
// [R2] Restart delay 0 to 60 s, default 1.0
// [R3] Each restart decrements remaining retries
// [R4] Trips beyond count leave drive tripped
// [R5] Fault reset reloads remaining retry count
// [R6] Thirty trip-free seconds restore the count
// [R7] No restart after undervoltage, estop, overheat, hardware
// [R8] Delay expiry starts speed search acceleration
// [R9] Count zero means never restart
// [R10] Input five code 12 selects motor two
// [R11] Exactly one motor set active
// [R12] Operator changes selection only when stopped
// [R13] Second set replaces first-set parameters
// [R14] Fan mode 0 runs until undervoltage
// [R15] Fan mode 1 follows run command
// [R16] Fan mode 1 runs while heatsink hot
// [R17] Fault mode 0 keeps drive running
// [R18] Output code 18 signals fan alarm
// [R19] Fault mode 1 stops drive, shows fault
// [R20] Output code 17 is general fault output
module trip_restart_fan_supervisor
   import supervisor_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trip,
   input wire logic trip_no_restart,
   input wire logic fault_reset,
   input wire logic run_cmd,
   input wire logic output_active,
   input wire logic motor_stopped,
   input wire logic multi_input_five,
   input wire logic heatsink_hot,
   input wire logic undervoltage,
   input wire logic fan_fail,
   input wire logic [15:0] motor1_param [MOTOR2_WORDS],
   output logic [15:0] active_param [MOTOR2_WORDS],
   output logic second_motor_active,
   output logic restart_start,
   output logic drive_tripped,
   output logic fan_run,
   output logic fan_stop_drive,
   output logic fault_display,
   output logic digital_output,
   output logic relay_output
);
   supervisor_if sif ();
   restart_state_t state_q;
   logic [3:0] restart_retry_count_q;
   logic [3:0] remaining_q;
   logic [9:0] restart_delay_time_q;
   logic [9:0] delay_cnt_q;
   logic [8:0] quiet_cnt_q;
   logic quiet_armed_q;
   logic fan_control_mode_q;
   logic fan_fault_mode_q;
   logic [4:0] input_five_function_select_q;
   logic [4:0] digital_output_select_q;
   logic [4:0] relay_output_select_q;
   logic [15:0] second_motor_param_set_q [MOTOR2_WORDS];
   logic motor2_q;
   logic fan_fault_q;
   logic general_fault;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [3:0] wr_idx;
   logic trip_event;

   tick_divider #(.TICK_LEN(TICK_LEN)) u_tick (
      .clk(clk),
      .srst(srst),
      .bus(sif)
   );

   fan_control u_fan (
      .clk(clk),
      .srst(srst),
      .fan_mode(fan_control_mode_q),
      .run_cmd(run_cmd),
      .output_active(output_active),
      .heatsink_hot(heatsink_hot),
      .undervoltage(undervoltage),
      .fan_fail(fan_fail),
      .bus(sif)
   );

   // APB decode; zero wait states, unmapped addresses answer with an error
   assign wr_idx = 4'((paddr - ADDR_MOTOR2_BASE) >> 2);
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr < ADDR_MOTOR2_BASE + 8'(MOTOR2_WORDS * 4));
   assign wr_en = psel && penable && pwrite && addr_ok;
   assign rd_en = psel && !penable && !pwrite; // Setup phase, so data stands at the access edge
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // Settings registers; out-of-range writes are clipped to the legal maximum
   always_ff @(posedge clk) begin
      if (srst) begin
         restart_retry_count_q <= RETRY_RESET; // see [R1]
         restart_delay_time_q <= DELAY_RESET; // see [R2]
         fan_control_mode_q <= 1'b0;
         fan_fault_mode_q <= 1'b0;
         input_five_function_select_q <= IN5_RESET;
         digital_output_select_q <= DO_RESET;
         relay_output_select_q <= RO_RESET;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_RETRY: begin
               restart_retry_count_q <= (pwdata[3:0] > RETRY_MAX || pwdata[31:4] != 28'h0)
                  ? RETRY_MAX : pwdata[3:0]; // see [R1]
            end
            ADDR_DELAY: begin
               restart_delay_time_q <= (pwdata[9:0] > DELAY_MAX || pwdata[31:10] != 22'h0)
                  ? DELAY_MAX : pwdata[9:0]; // see [R2]
            end
            ADDR_CTRL: begin
               fan_control_mode_q <= pwdata[CTRL_FAN_MODE];
               fan_fault_mode_q <= pwdata[CTRL_FAN_FAULT];
               input_five_function_select_q <= pwdata[CTRL_IN5_LSB +: 5];
               digital_output_select_q <= (pwdata[CTRL_DO_LSB +: 5] > OUT_SEL_MAX)
                  ? OUT_SEL_MAX : pwdata[CTRL_DO_LSB +: 5]; // see [R18]
               relay_output_select_q <= (pwdata[CTRL_RO_LSB +: 5] > OUT_SEL_MAX)
                  ? OUT_SEL_MAX : pwdata[CTRL_RO_LSB +: 5]; // see [R18]
            end
            default: begin
            end
         endcase
      end
   end

   // Second motor parameter words
   genvar gi;
   generate
      for (gi = 0; gi < MOTOR2_WORDS; gi++) begin : g_m2
         always_ff @(posedge clk) begin
            if (srst) begin
               second_motor_param_set_q[gi] <= 16'h0000;
            end else if (wr_en && paddr >= ADDR_MOTOR2_BASE && wr_idx == 4'(gi)) begin
               second_motor_param_set_q[gi] <= pwdata[15:0];
            end
         end
         // One set drives the outputs at a time
         always_ff @(posedge clk) begin
            if (srst) begin
               active_param[gi] <= 16'h0000;
            end else begin
               active_param[gi] <= motor2_q ? second_motor_param_set_q[gi]
                  : motor1_param[gi]; // see [R11] see [R13]
            end
         end
      end
   endgenerate

   // Read mux, loaded in the setup phase so the word is ready when pready is sampled
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         prdata <= 32'h00000000;
         unique case (paddr)
            ADDR_RETRY: prdata <= {20'h0, remaining_q, 4'h0, restart_retry_count_q};
            ADDR_DELAY: prdata <= {22'h0, restart_delay_time_q};
            ADDR_CTRL: prdata <= {3'h0, relay_output_select_q, 3'h0, digital_output_select_q,
               3'h0, input_five_function_select_q, 6'h0, fan_fault_mode_q,
               fan_control_mode_q};
            ADDR_STATUS: prdata <= {24'h0, sif.fan_on, fan_fault_q, motor2_q,
               drive_tripped, 2'h0, state_q};
            default: begin
               if (addr_ok) begin
                  prdata <= {16'h0, second_motor_param_set_q[wr_idx]};
               end
            end
         endcase
      end
   end

   // Motor select latched only while stopped; selection changes never while running
   always_ff @(posedge clk) begin
      if (srst) begin
         motor2_q <= 1'b0;
      end else if (motor_stopped) begin // see [R12]
         motor2_q <= multi_input_five && (input_five_function_select_q == SEL_MOTOR2); // see [R10]
      end
   end
   assign second_motor_active = motor2_q;

   // Fan fault is sticky until a fault reset; a new fault wins over the clear
   always_ff @(posedge clk) begin
      if (srst) begin
         fan_fault_q <= 1'b0;
      end else if (sif.fan_fault) begin
         fan_fault_q <= 1'b1;
      end else if (fault_reset) begin
         fan_fault_q <= 1'b0;
      end
   end
   assign fan_run = sif.fan_on;
   assign fan_stop_drive = fan_fault_q && fan_fault_mode_q; // see [R17] see [R19]
   assign fault_display = fan_stop_drive || drive_tripped; // see [R19]
   assign general_fault = drive_tripped || fan_stop_drive;

   // Configurable alarm outputs
   always_ff @(posedge clk) begin
      if (srst) begin
         digital_output <= 1'b0;
         relay_output <= 1'b0;
      end else begin
         digital_output <= (digital_output_select_q == OUT_FAN_ALARM && fan_fault_q) ||
            (digital_output_select_q == OUT_FAULT && general_fault); // see [R18] see [R20]
         relay_output <= (relay_output_select_q == OUT_FAN_ALARM && fan_fault_q) ||
            (relay_output_select_q == OUT_FAULT && general_fault); // see [R18] see [R20]
      end
   end

   assign trip_event = trip || trip_no_restart;

   // Restart sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_RUN;
         delay_cnt_q <= 10'h000;
         restart_start <= 1'b0;
      end else begin
         restart_start <= 1'b0;
         unique case (state_q)
            ST_RUN: begin
               if (trip_no_restart) begin
                  state_q <= ST_LOCK; // see [R7]
               end else if (trip) begin
                  state_q <= (remaining_q == 4'h0) ? ST_LOCK : ST_WAIT; // see [R4] see [R9]
                  delay_cnt_q <= 10'h000;
               end
            end
            ST_WAIT: begin
               if (fault_reset) begin
                  state_q <= ST_RUN;
               end else if (trip_no_restart) begin
                  state_q <= ST_LOCK; // see [R7]
               end else if (delay_cnt_q >= restart_delay_time_q) begin
                  state_q <= ST_RUN;
                  restart_start <= 1'b1; // see [R8]
               end else if (sif.tick) begin
                  delay_cnt_q <= delay_cnt_q + 10'h001; // see [R2]
               end
            end
            ST_LOCK: begin
               if (fault_reset) begin
                  state_q <= ST_RUN;
               end
            end
            default: begin
               state_q <= ST_LOCK; // Unused code falls back to the safe tripped state
            end
         endcase
      end
   end
   assign drive_tripped = (state_q != ST_RUN);

   // Remaining retries and 30 s trip-free window
   always_ff @(posedge clk) begin
      if (srst) begin
         remaining_q <= RETRY_RESET;
         quiet_armed_q <= 1'b0;
         quiet_cnt_q <= 9'h000;
      end else if (fault_reset) begin
         remaining_q <= restart_retry_count_q; // see [R5]
         quiet_armed_q <= 1'b0;
      end else if (restart_start) begin
         remaining_q <= remaining_q - 4'h1; // see [R3]
         quiet_armed_q <= 1'b1;
         quiet_cnt_q <= 9'h000;
      end else if (quiet_armed_q) begin
         if (trip_event) begin
            quiet_armed_q <= 1'b0;
         end else if (quiet_cnt_q == 9'(QUIET_TICKS)) begin
            remaining_q <= restart_retry_count_q; // see [R6]
            quiet_armed_q <= 1'b0;
         end else if (sif.tick) begin
            quiet_cnt_q <= quiet_cnt_q + 9'h001;
         end
      end
   end

   // Restart only after a trip with retries left
   restart_pulse_a: assert property (@(posedge clk) disable iff (srst) // see [R3]
      restart_start |-> $past(state_q) == ST_WAIT && $past(remaining_q) != 4'h0)
      else $error("restart without retries");
   decrement_a: assert property (@(posedge clk) disable iff (srst) // see [R3]
      restart_start && !fault_reset |=> remaining_q == $past(remaining_q) - 4'h1)
      else $error("retry count not decremented");
   zero_lock_a: assert property (@(posedge clk) disable iff (srst) // see [R9]
      state_q == ST_RUN && trip && !trip_no_restart && remaining_q == 4'h0
      |=> state_q == ST_LOCK)
      else $error("zero retries did not lock");
   no_restart_a: assert property (@(posedge clk) disable iff (srst) // see [R7]
      trip_no_restart && !fault_reset |=> state_q == ST_LOCK)
      else $error("restart allowed after hard trip");
   reset_reload_a: assert property (@(posedge clk) disable iff (srst) // see [R5]
      fault_reset |=> remaining_q == $past(restart_retry_count_q))
      else $error("fault reset did not reload");
   lock_hold_a: assert property (@(posedge clk) disable iff (srst) // see [R4]
      state_q == ST_LOCK && !fault_reset |=> state_q == ST_LOCK && !restart_start)
      else $error("locked state left");
   motor_sel_a: assert property (@(posedge clk) disable iff (srst) // see [R12]
      !motor_stopped |=> $stable(motor2_q))
      else $error("motor set changed while running");
   // Fan demand is registered from this cycle's mode, so it shows one edge later
   fan_mode0_a: assert property (@(posedge clk) disable iff (srst) // see [R14]
      !fan_control_mode_q && !undervoltage |=> fan_run)
      else $error("fan off in mode 0");
   fan_hot_a: assert property (@(posedge clk) disable iff (srst) // see [R16]
      fan_control_mode_q && heatsink_hot |=> fan_run)
      else $error("fan off while hot");
   fan_stop_a: assert property (@(posedge clk) disable iff (srst) // see [R17]
      fan_fault_q && !fan_fault_mode_q |-> !fan_stop_drive)
      else $error("fan fault stopped drive in mode 0");
   // Steps of a retried trip: wait entered with a fresh delay, then the restart pulse
   sequence retry_trip_s;
      state_q == ST_RUN && trip && !trip_no_restart && remaining_q != 4'h0;
   endsequence
   sequence wait_fresh_s;
      state_q == ST_WAIT && delay_cnt_q == 10'h000;
   endsequence
   sequence delay_done_s;
      state_q == ST_WAIT && !fault_reset && !trip_no_restart
         && delay_cnt_q >= restart_delay_time_q;
   endsequence
   trip_wait_a: assert property (@(posedge clk) disable iff (srst) // see [R2]
      retry_trip_s |=> wait_fresh_s)
      else $error("trip with retries did not wait");
   restart_due_a: assert property (@(posedge clk) disable iff (srst) // see [R8]
      delay_done_s |=> restart_start && state_q == ST_RUN)
      else $error("restart missing after delay");
   quiet_reload_a: assert property (@(posedge clk) disable iff (srst) // see [R6]
      quiet_armed_q && !fault_reset && !restart_start && !trip_event
      && quiet_cnt_q == 9'(QUIET_TICKS) |=> remaining_q == $past(restart_retry_count_q))
      else $error("retry count not restored after quiet window");
   fan_alarm_a: assert property (@(posedge clk) disable iff (srst) // see [R18]
      digital_output_select_q == OUT_FAN_ALARM && fan_fault_q |=> digital_output)
      else $error("fan alarm output missing");
   fault_out_a: assert property (@(posedge clk) disable iff (srst) // see [R20]
      relay_output_select_q == OUT_FAULT && general_fault |=> relay_output)
      else $error("fault relay output missing");
endmodule : trip_restart_fan_supervisor

// ---- drive_side_model.sv ----
`timescale 1ns/1ps
// Keypad, terminals and power stage as the supervisor sees them
module drive_side_model
   import supervisor_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic run_req,
   input wire logic drive_tripped,
   output logic run_cmd,
   output logic output_active,
   output logic motor_stopped,
   output logic [15:0] motor1_param [MOTOR2_WORDS]
);
   // Output stage lags the command and drops on a trip, like real hardware
   always_ff @(posedge clk) begin
      if (srst) begin
         run_cmd <= 1'b0;
         output_active <= 1'b0;
      end else begin
         run_cmd <= run_req;
         output_active <= run_cmd & ~drive_tripped;
      end
   end
   // Motor counts as stopped only once the output is off
   assign motor_stopped = ~run_cmd & ~output_active;
   // First-set parameters, fixed and distinct from the second set
   always_comb begin
      for (int k = 0; k < MOTOR2_WORDS; k++) begin
         motor1_param[k] = 16'h1000 + 16'(k);
      end
   end
endmodule : drive_side_model

// ---- trip_restart_fan_supervisor_tb_top.sv ----
`timescale 1ns/1ps
module trip_restart_fan_supervisor_tb_top;
   import supervisor_pkg::*;
   localparam int TL = 4;
   logic clk, srst, psel, penable, pwrite, pready, pslverr, errb;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic trip, trip_no_restart, fault_reset, run_req, run_cmd, output_active, motor_stopped;
   logic multi_input_five, heatsink_hot, undervoltage, fan_fail;
   logic [15:0] motor1_param [MOTOR2_WORDS];
   logic [15:0] active_param [MOTOR2_WORDS];
   logic second_motor_active, restart_start, drive_tripped, fan_run, fan_stop_drive;
   logic fault_display, digital_output, relay_output;
   int err_total = 0;
   int compares = 0;

   // Short tick keeps the 30 s window at 1200 cycles
   trip_restart_fan_supervisor #(.TICK_LEN(TL)) dut (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trip(trip), .trip_no_restart(trip_no_restart),
      .fault_reset(fault_reset), .run_cmd(run_cmd), .output_active(output_active),
      .motor_stopped(motor_stopped), .multi_input_five(multi_input_five),
      .heatsink_hot(heatsink_hot), .undervoltage(undervoltage), .fan_fail(fan_fail),
      .motor1_param(motor1_param), .active_param(active_param),
      .second_motor_active(second_motor_active), .restart_start(restart_start),
      .drive_tripped(drive_tripped), .fan_run(fan_run), .fan_stop_drive(fan_stop_drive),
      .fault_display(fault_display), .digital_output(digital_output),
      .relay_output(relay_output));

   drive_side_model far (.clk(clk), .srst(srst), .run_req(run_req),
      .drive_tripped(drive_tripped), .run_cmd(run_cmd), .output_active(output_active),
      .motor_stopped(motor_stopped), .motor1_param(motor1_param));

   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // One APB transfer; a write lands and read data is taken at the access edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      errb = pslverr;
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(n, e, rdat);
   endtask : rd

   // Remaining count sits above a setting of two
   task automatic rem(input logic [3:0] e);
      rd("retry word", ADDR_RETRY, {20'h0, e, 8'h02});
   endtask : rem

   task automatic clr;
      @(posedge clk);
      fault_reset <= 1'b1;
      @(posedge clk);
      fault_reset <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : clr

   // Pulse a trip, then count cycles to a restart; 100 means none came
   task automatic trip_wait(input logic hw, output int n);
      @(posedge clk);
      if (hw) trip_no_restart <= 1'b1;
      else trip <= 1'b1;
      @(posedge clk);
      trip <= 1'b0;
      trip_no_restart <= 1'b0;
      n = 0;
      while (restart_start !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
   endtask : trip_wait

   task automatic regs_test;
      rd("retry rst", ADDR_RETRY, 32'h00000000);
      rd("delay rst", ADDR_DELAY, 32'h0000000A);
      rd("ctrl rst", ADDR_CTRL, 32'h110C0700);
      apb(1'b1, ADDR_RETRY, 32'h0000000F);
      rd("retry clip", ADDR_RETRY, 32'h0000000A);
      apb(1'b1, ADDR_DELAY, 32'h000003FF);
      rd("delay clip", ADDR_DELAY, 32'h00000258);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h1, {31'h0, errb});
   endtask : regs_test

   task automatic restart_test;
      int n;
      apb(1'b1, ADDR_RETRY, 32'h00000002);
      apb(1'b1, ADDR_DELAY, 32'h00000002);
      clr;
      rem(4'h2);
      trip_wait(1'b0, n);
      chk("delay", 32'h1, 32'(n >= 4 && n <= 16));
      rem(4'h1);
      trip_wait(1'b0, n);
      chk("again", 32'h1, 32'(n < 100));
      rem(4'h0);
      trip_wait(1'b0, n);
      chk("lockout", 32'h0, 32'(n < 100));
      chk("held", 32'h1, {31'h0, drive_tripped});
      clr;
      rem(4'h2);
      chk("cleared", 32'h0, {31'h0, drive_tripped});
      trip_wait(1'b0, n);
      rem(4'h1);
      repeat (1400) @(posedge clk);
      rem(4'h2);
      trip_wait(1'b1, n);
      chk("hard trip", 32'h0, 32'(n < 100));
      chk("hard held", 32'h1, {31'h0, drive_tripped});
      clr;
      apb(1'b1, ADDR_RETRY, 32'h00000000);
      clr;
      trip_wait(1'b0, n);
      chk("zero count", 32'h0, 32'(n < 100));
      clr;
   endtask : restart_test

   // Selection only toggled with the motor stopped
   task automatic motor_test;
      for (int k = 0; k < MOTOR2_WORDS; k++) begin
         apb(1'b1, ADDR_MOTOR2_BASE + 8'(4 * k), {16'h0, 16'hA000 + 16'(k)});
      end
      @(posedge clk);
      multi_input_five <= 1'b1;
      repeat (4) @(posedge clk);
      chk("in5 off", 32'h0, {31'h0, second_motor_active});
      apb(1'b1, ADDR_CTRL, 32'h110C0C00);
      repeat (4) @(posedge clk);
      chk("in5 on", 32'h1, {31'h0, second_motor_active});
      for (int k = 0; k < MOTOR2_WORDS; k++) begin
         chk("set two", {16'h0, 16'hA000 + 16'(k)}, {16'h0, active_param[k]});
      end
      multi_input_five <= 1'b0;
      repeat (4) @(posedge clk);
      chk("back one", 32'h0, {31'h0, second_motor_active});
      for (int k = 0; k < MOTOR2_WORDS; k++) begin
         chk("set one", {16'h0, 16'h1000 + 16'(k)}, {16'h0, active_param[k]});
      end
   endtask : motor_test

   task automatic fan_test;
      apb(1'b1, ADDR_CTRL, 32'h110C0700);
      chk("mode0 on", 32'h1, {31'h0, fan_run});
      undervoltage <= 1'b1;
      repeat (3) @(posedge clk);
      chk("mode0 uv", 32'h0, {31'h0, fan_run});
      undervoltage <= 1'b0;
      apb(1'b1, ADDR_CTRL, 32'h110C0701);
      repeat (3) @(posedge clk);
      chk("mode1 idle", 32'h0, {31'h0, fan_run});
      run_req <= 1'b1;
      repeat (4) @(posedge clk);
      chk("mode1 run", 32'h1, {31'h0, fan_run});
      run_req <= 1'b0;
      repeat (4) @(posedge clk);
      chk("mode1 stop", 32'h0, {31'h0, fan_run});
      heatsink_hot <= 1'b1;
      repeat (3) @(posedge clk);
      chk("mode1 hot", 32'h1, {31'h0, fan_run});
      heatsink_hot <= 1'b0;
   endtask : fan_test

   task automatic fault_test;
      apb(1'b1, ADDR_CTRL, 32'h11120700);
      fan_fail <= 1'b1;
      repeat (3) @(posedge clk);
      chk("keep run", 32'h0, {31'h0, fan_stop_drive});
      chk("dout alarm", 32'h1, {31'h0, digital_output});
      chk("relay fault", 32'h0, {31'h0, relay_output});
      apb(1'b1, ADDR_CTRL, 32'h12110700);
      // Selector lands at the access edge, the registered outputs one edge later
      repeat (2) @(posedge clk);
      chk("relay alarm", 32'h1, {31'h0, relay_output});
      chk("dout fault", 32'h0, {31'h0, digital_output});
      apb(1'b1, ADDR_CTRL, 32'h11120702);
      repeat (3) @(posedge clk);
      chk("stop drive", 32'h1, {31'h0, fan_stop_drive});
      chk("display", 32'h1, {31'h0, fault_display});
      chk("relay on", 32'h1, {31'h0, relay_output});
      fan_fail <= 1'b0;
      clr;
      chk("fault gone", 32'h0, {31'h0, fan_stop_drive});
   endtask : fault_test

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Tests need about 1900 cycles; allow generous margin
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("watchdog expired");
      stop_test();
   end

   initial begin
      {srst, psel, penable, pwrite, trip, trip_no_restart, fault_reset} = 7'h40;
      {run_req, multi_input_five, heatsink_hot, undervoltage, fan_fail} = 5'h00;
      srst = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      regs_test();
      restart_test();
      motor_test();
      fan_test();
      fault_test();
      stop_test();
   end
endmodule : trip_restart_fan_supervisor_tb_top
